// ---- src/zao_top.sv ----
//Contract
// - green dark while zone input in alarm
// - green steady again when alarm becomes secure
// - trouble blinks green 2cps 30% until ack
// - alarm or trouble lights red, blinking first
// - acknowledge turns blinking red steady
// - new event turns steady red blinking again
// - red off after secure, ack, then reset
// - non-latch follows alarm, clears when secure
// - latched output holds until zone reset
// - pulsed output off after three seconds
// - reset clears pulsed and timed immediately
// - realarm restarts pulsed and timed period
// - timed output uses programmed on-period
// - audible common pulses during exit/entry delay
// - audible output silenced by acknowledge
// - system-arm output follows master arm input
// - bridge matrix maps any inputs to outputs
// - default bridge is one to one
// - bridged output uses its own type
// - factory defaults latched, audible, non-latch
// - acknowledge input steadies reds, silences audible
// - button acknowledges alarm or resets secured zone
`timescale 1ns/10ps
`default_nettype none
module zao_top #(
	parameter int NZ = zao_pkg::ZONES,
	parameter int NO = zao_pkg::OUTS,
	parameter int TW = zao_pkg::TIME_W,
	parameter int TICK_CYC = zao_pkg::TICK_CYCLES,
	parameter int BLINK_CYC = zao_pkg::BLINK_CYCLES,
	parameter int BLINK_ON = zao_pkg::BLINK_ON_CYCLES,
	parameter int DPULSE_CYC = zao_pkg::DLY_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// loop state per zone, two bits each (secure/alarm/trouble)
	input wire logic [2*NZ-1:0] loop_state,
	input wire logic ack_n,
	input wire logic reset_n,
	input wire logic [NZ-1:0] zone_btn,
	input wire logic arm_n,
	input wire logic delay_active,
	// configuration; cfg_load copies these over the factory defaults
	input wire logic cfg_load,
	input wire logic [NZ*NO-1:0] cfg_map,
	input wire logic [3*NO-1:0] cfg_ind_type,
	input wire logic [TW*NO-1:0] cfg_ind_secs,
	input wire logic [2:0] cfg_com1_type,
	input wire logic [2:0] cfg_com2_type,
	input wire logic [TW-1:0] cfg_com1_secs,
	input wire logic [TW-1:0] cfg_com2_secs,
	output logic [NZ-1:0] led_loop,
	output logic [NZ-1:0] led_alarm,
	output logic [NZ-1:0] zone_acked,
	output logic [NO-1:0] ind_out,
	output logic [1:0] com_out
);
	import zao_pkg::*;
	initial begin
		if (NZ != 8 || NO != 8)
			$error("zao_top: default bridge serves 8 by 8 only");
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2*NZ-1:0] loop_s1_r, loop_s2_r;
	logic [NZ+3:0] pin_s1_r, pin_s2_r;
	logic [NZ+3:0] pin_raw;
	assign pin_raw = {delay_active, arm_n, reset_n, ack_n, zone_btn};

	// two flops on every loop, button, ack, reset, arm and delay pin; stage one feeds only stage two
	always_ff @(posedge clk) begin
		if (srst) begin
			loop_s1_r <= '0;
			loop_s2_r <= '0;
			pin_s1_r <= {1'b0, 3'h7, {NZ{1'b0}}};
			pin_s2_r <= {1'b0, 3'h7, {NZ{1'b0}}};
		end else if (ce) begin
			loop_s1_r <= loop_state;
			loop_s2_r <= loop_s1_r;
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	logic [NZ-1:0] btn_s, btn_prev_r;
	logic ack_s, rst_s, armed_s, dly_s, ack_prev_r, rst_prev_r;
	assign btn_s = pin_s2_r[NZ-1:0];
	assign ack_s = ~pin_s2_r[NZ];
	assign rst_s = ~pin_s2_r[NZ+1];
	assign armed_s = ~pin_s2_r[NZ+2];
	assign dly_s = pin_s2_r[NZ+3];

	// ****************************************
	// timebase
	// ****************************************
	logic sec_tick, blink, dly_pulse;
	zao_timebase #(
		.TICK_CYC(TICK_CYC),
		.BLINK_CYC(BLINK_CYC),
		.BLINK_ON(BLINK_ON),
		.DPULSE_CYC(DPULSE_CYC)
	) u_tb (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.sec_tick(sec_tick),
		.blink(blink),
		.dly_pulse(dly_pulse)
	);

	// ****************************************
	// configuration store
	// ****************************************
	logic [NZ*NO-1:0] map_r, map_nxt;
	logic [3*NO-1:0] itype_r, itype_nxt;
	logic [TW*NO-1:0] isecs_r, isecs_nxt;
	logic [2:0] c1t_r, c1t_nxt, c2t_r, c2t_nxt;
	logic [TW-1:0] c1s_r, c1s_nxt, c2s_r, c2s_nxt;

	// defaults at reset; a load replaces the whole set at once
	always_comb begin
		map_nxt = map_r;
		itype_nxt = itype_r;
		isecs_nxt = isecs_r;
		c1t_nxt = c1t_r;
		c2t_nxt = c2t_r;
		c1s_nxt = c1s_r;
		c2s_nxt = c2s_r;
		if (cfg_load) begin
			map_nxt = cfg_map;
			itype_nxt = cfg_ind_type;
			isecs_nxt = cfg_ind_secs;
			c1t_nxt = cfg_com1_type;
			c2t_nxt = cfg_com2_type;
			c1s_nxt = cfg_com1_secs;
			c2s_nxt = cfg_com2_secs;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			map_r <= MAP_DEFAULT;
			itype_r <= {NO{IND_TYPE_DEFAULT}};
			isecs_r <= '0;
			c1t_r <= COM1_TYPE_DEFAULT;
			c2t_r <= COM2_TYPE_DEFAULT;
			c1s_r <= '0;
			c2s_r <= '0;
		end else if (ce) begin
			map_r <= map_nxt;
			itype_r <= itype_nxt;
			isecs_r <= isecs_nxt;
			c1t_r <= c1t_nxt;
			c2t_r <= c2t_nxt;
			c1s_r <= c1s_nxt;
			c2s_r <= c2s_nxt;
		end
	end

	// ****************************************
	// zone state: acknowledge, alarm memory, trouble memory
	// ****************************************
	logic [NZ-1:0] in_alarm, in_trbl, in_secure, event_any;
	logic [NZ-1:0] alm_prev_r, trb_prev_r, alm_rise, alm_fall;
	logic [NZ-1:0] mem_r, mem_nxt, ack_r, ack_nxt, tmem_r, tmem_nxt;
	logic [NZ-1:0] zack_evt, zrst_evt;
	logic ack_edge, rst_edge;

	always_comb begin
		for (int i = 0; i < NZ; i++) begin
			in_alarm[i] = (loop_s2_r[2*i +: 2] == 2'(ZAO_LOOP_ALARM));
			in_trbl[i] = (loop_s2_r[2*i +: 2] == 2'(ZAO_LOOP_TROUBLE));
			in_secure[i] = ~in_alarm[i] & ~in_trbl[i];
		end
	end

	assign alm_rise = in_alarm & ~alm_prev_r;
	assign alm_fall = ~in_alarm & alm_prev_r;
	assign event_any = alm_rise | (in_trbl & ~trb_prev_r);
	assign ack_edge = ack_s & ~ack_prev_r;
	assign rst_edge = rst_s & ~rst_prev_r;

	// per-zone ack and reset events from the common inputs and buttons
	always_comb begin
		for (int i = 0; i < NZ; i++) begin
			zack_evt[i] = ack_edge | (btn_s[i] & ~btn_prev_r[i] & mem_r[i] & ~ack_r[i]);
			zrst_evt[i] = (rst_edge | (btn_s[i] & ~btn_prev_r[i] & ack_r[i]))
			              & ack_r[i] & in_secure[i];
		end
	end

	// a new event wins over an ack or reset in the same cycle
	always_comb begin
		mem_nxt = mem_r;
		ack_nxt = ack_r;
		tmem_nxt = tmem_r;
		for (int i = 0; i < NZ; i++) begin
			if (zack_evt[i] && mem_r[i])
				ack_nxt[i] = 1'b1;
			if (zrst_evt[i]) begin
				mem_nxt[i] = 1'b0;
				ack_nxt[i] = 1'b0;
			end
			if (ack_nxt[i] && in_secure[i])
				tmem_nxt[i] = 1'b0;
			if (in_trbl[i])
				tmem_nxt[i] = 1'b1;
			if (event_any[i]) begin
				mem_nxt[i] = 1'b1;
				ack_nxt[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mem_r <= '0;
			ack_r <= '0;
			tmem_r <= '0;
			alm_prev_r <= '0;
			trb_prev_r <= '0;
			btn_prev_r <= '0;
			ack_prev_r <= 1'b0;
			rst_prev_r <= 1'b0;
		end else if (ce) begin
			mem_r <= mem_nxt;
			ack_r <= ack_nxt;
			tmem_r <= tmem_nxt;
			alm_prev_r <= in_alarm;
			trb_prev_r <= in_trbl;
			btn_prev_r <= btn_s;
			ack_prev_r <= ack_s;
			rst_prev_r <= rst_s;
		end
	end

	// ****************************************
	// indicators
	// ****************************************
	logic [NZ-1:0] loop_led_r, loop_led_nxt, alm_led_r, alm_led_nxt;

	always_comb begin
		for (int i = 0; i < NZ; i++) begin
			if (in_alarm[i])
				loop_led_nxt[i] = 1'b0;
			else if (tmem_r[i])
				loop_led_nxt[i] = blink;
			else
				loop_led_nxt[i] = 1'b1;
			alm_led_nxt[i] = mem_r[i] & (ack_r[i] | blink);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			loop_led_r <= '0;
			alm_led_r <= '0;
		end else if (ce) begin
			loop_led_r <= loop_led_nxt;
			alm_led_r <= alm_led_nxt;
		end
	end

	assign led_loop = loop_led_r;
	assign led_alarm = alm_led_r;
	assign zone_acked = ack_r;

	// ****************************************
	// bridge matrix and outputs
	// ****************************************
	logic [NO-1:0] o_lvl, o_evt, o_ack, o_rst;
	logic any_lvl, any_evt, any_ack, any_rst;

	// each output ORs every mapped zone; map bit z*NO+o links zone z to output o
	always_comb begin
		o_lvl = '0;
		o_evt = '0;
		o_ack = '0;
		o_rst = '0;
		for (int o = 0; o < NO; o++) begin
			for (int z = 0; z < NZ; z++) begin
				if (map_r[z*NO+o]) begin
					o_lvl[o] = o_lvl[o] | in_alarm[z];
					o_evt[o] = o_evt[o] | alm_rise[z];
					o_ack[o] = o_ack[o] | (zack_evt[z] & mem_r[z]);
					o_rst[o] = o_rst[o] | zrst_evt[z];
				end
			end
		end
	end

	assign any_lvl = |in_alarm;
	assign any_evt = |alm_rise;
	assign any_ack = ack_edge | |(zack_evt & mem_r);
	assign any_rst = |zrst_evt;

	genvar g;
	generate
		for (g = 0; g < NO; g++) begin : g_ind
			zao_output #(.TW(TW)) u_ind (
				.clk(clk),
				.srst(srst),
				.ce(ce),
				.otype(zao_otype_t'(itype_r[3*g +: 3])),
				.on_secs(isecs_r[TW*g +: TW]),
				.sec_tick(sec_tick),
				.act_lvl(o_lvl[g]),
				.act_evt(o_evt[g]),
				.ack_evt(o_ack[g]),
				.rst_evt(o_rst[g]),
				.armed(armed_s),
				.delay_run(1'b0),
				.dly_pulse(1'b0),
				.out(ind_out[g])
			);
		end
	endgenerate

	zao_output #(.TW(TW)) u_com1 (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.otype(zao_otype_t'(c1t_r)),
		.on_secs(c1s_r),
		.sec_tick(sec_tick),
		.act_lvl(any_lvl),
		.act_evt(any_evt),
		.ack_evt(any_ack),
		.rst_evt(any_rst),
		.armed(armed_s),
		.delay_run(dly_s),
		.dly_pulse(dly_pulse),
		.out(com_out[0])
	);

	zao_output #(.TW(TW)) u_com2 (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.otype(zao_otype_t'(c2t_r)),
		.on_secs(c2s_r),
		.sec_tick(sec_tick),
		.act_lvl(any_lvl),
		.act_evt(any_evt),
		.ack_evt(any_ack),
		.rst_evt(any_rst),
		.armed(armed_s),
		.delay_run(dly_s),
		.dly_pulse(dly_pulse),
		.out(com_out[1])
	);
endmodule : zao_top
`default_nettype wire

// ---- shared/zao_pkg.sv ----
`default_nettype none
package zao_pkg;
	// ****************************************
	// geometry and output types
	// ****************************************
	localparam int ZONES = 8;
	localparam int OUTS = 8;
	localparam int TIME_W = 8;

	typedef enum logic [2:0] {
		ZAO_OT_NONLATCH = 3'h0,
		ZAO_OT_LATCHED = 3'h1,
		ZAO_OT_PULSED = 3'h2,
		ZAO_OT_TIMED = 3'h3,
		ZAO_OT_AUDIBLE = 3'h4,
		ZAO_OT_SYSARM = 3'h5
	} zao_otype_t;

	typedef enum logic [1:0] {
		ZAO_LOOP_SECURE = 2'h0,
		ZAO_LOOP_ALARM = 2'h1,
		ZAO_LOOP_TROUBLE = 2'h2
	} zao_loop_t;

	// ****************************************
	// timing
	// ****************************************
	localparam longint CLK_HZ = 25000000;
	localparam int TICK_CYCLES = int'(CLK_HZ);
	localparam int PULSE_SEC = 3;
	localparam int BLINK_PER_SEC = 2;
	localparam int BLINK_ON_PCT = 30;
	localparam int BLINK_CYCLES = TICK_CYCLES / BLINK_PER_SEC;
	localparam int BLINK_ON_CYCLES = (BLINK_CYCLES * BLINK_ON_PCT) / 100;
	localparam int DLY_PULSE_CYCLES = TICK_CYCLES / 4;

	// ****************************************
	// factory defaults
	// ****************************************
	localparam logic [63:0] MAP_DEFAULT = 64'h8040_2010_0804_0201;
	localparam logic [2:0] IND_TYPE_DEFAULT = 3'h1;
	localparam logic [2:0] COM1_TYPE_DEFAULT = 3'h4;
	localparam logic [2:0] COM2_TYPE_DEFAULT = 3'h0;
endpackage : zao_pkg
`default_nettype wire

// ---- src/zao_timebase.sv ----
`timescale 1ns/10ps
`default_nettype none
module zao_timebase #(
	parameter int TICK_CYC = zao_pkg::TICK_CYCLES,
	parameter int BLINK_CYC = zao_pkg::BLINK_CYCLES,
	parameter int BLINK_ON = zao_pkg::BLINK_ON_CYCLES,
	parameter int DPULSE_CYC = zao_pkg::DLY_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	output logic sec_tick,
	output logic blink,
	output logic dly_pulse
);
	import zao_pkg::*;
	initial begin
		if (TICK_CYC < 4 || BLINK_CYC < 2 || BLINK_ON < 1 || BLINK_ON >= BLINK_CYC
		    || DPULSE_CYC < 1)
			$error("zao_timebase: bad timing parameters");
	end

	logic [31:0] sec_cnt_r, sec_cnt_nxt;
	logic [31:0] bl_cnt_r, bl_cnt_nxt;
	logic [31:0] dp_cnt_r, dp_cnt_nxt;
	logic tick_r, tick_nxt, blink_r, blink_nxt, dp_r, dp_nxt;

	// free-running counters: one-second tick, 2 cps blink, delay pulse toggling every DPULSE_CYC cycles
	always_comb begin
		sec_cnt_nxt = sec_cnt_r + 32'h0000_0001;
		tick_nxt = 1'b0;
		if (sec_cnt_r == 32'(TICK_CYC - 1)) begin
			sec_cnt_nxt = 32'h0000_0000;
			tick_nxt = 1'b1;
		end
		bl_cnt_nxt = bl_cnt_r + 32'h0000_0001;
		if (bl_cnt_r == 32'(BLINK_CYC - 1))
			bl_cnt_nxt = 32'h0000_0000;
		blink_nxt = (bl_cnt_nxt < 32'(BLINK_ON));
		dp_cnt_nxt = dp_cnt_r + 32'h0000_0001;
		dp_nxt = dp_r;
		if (dp_cnt_r == 32'(DPULSE_CYC - 1)) begin
			dp_cnt_nxt = 32'h0000_0000;
			dp_nxt = ~dp_r;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sec_cnt_r <= 32'h0000_0000;
			bl_cnt_r <= 32'h0000_0000;
			dp_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b0;
			blink_r <= 1'b1;
			dp_r <= 1'b0;
		end else if (ce) begin
			sec_cnt_r <= sec_cnt_nxt;
			bl_cnt_r <= bl_cnt_nxt;
			dp_cnt_r <= dp_cnt_nxt;
			tick_r <= tick_nxt;
			blink_r <= blink_nxt;
			dp_r <= dp_nxt;
		end
	end

	assign sec_tick = tick_r & ce;
	assign blink = blink_r;
	assign dly_pulse = dp_r;
endmodule : zao_timebase
`default_nettype wire

// ---- src/zao_output.sv ----
`timescale 1ns/10ps
`default_nettype none
// one output channel of any programmed type
module zao_output #(
	parameter int TW = zao_pkg::TIME_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire zao_pkg::zao_otype_t otype,
	input wire logic [TW-1:0] on_secs,
	input wire logic sec_tick,
	input wire logic act_lvl,
	input wire logic act_evt,
	input wire logic ack_evt,
	input wire logic rst_evt,
	input wire logic armed,
	input wire logic delay_run,
	input wire logic dly_pulse,
	output logic out
);
	import zao_pkg::*;
	initial begin
		if (TW < 2 || TW > 16)
			$error("zao_output: TW out of range");
	end

	logic on_r, on_nxt;
	logic [TW-1:0] left_r, left_nxt;
	logic out_r, out_nxt;

	// on-state and remaining seconds for the selected behaviour
	always_comb begin
		on_nxt = on_r;
		left_nxt = left_r;
		case (otype)
			ZAO_OT_NONLATCH: begin
				on_nxt = act_lvl;
			end
			ZAO_OT_LATCHED: begin
				if (rst_evt)
					on_nxt = 1'b0;
				if (act_evt)
					on_nxt = 1'b1;
			end
			ZAO_OT_PULSED, ZAO_OT_TIMED: begin
				if (on_r && sec_tick) begin
					if (left_r <= TW'(1))
						on_nxt = 1'b0;
					else
						left_nxt = left_r - TW'(1);
				end
				if (rst_evt)
					on_nxt = 1'b0;
				// a fresh alarm restarts the full period, reset or not
				if (act_evt) begin
					on_nxt = 1'b1;
					left_nxt = (otype == ZAO_OT_PULSED) ? TW'(PULSE_SEC) : on_secs;
				end
				if (act_evt && otype == ZAO_OT_TIMED && on_secs == TW'(0))
					on_nxt = 1'b0;
			end
			ZAO_OT_AUDIBLE: begin
				if (ack_evt)
					on_nxt = 1'b0;
				if (act_evt)
					on_nxt = 1'b1;
			end
			default: begin
				on_nxt = 1'b0;
			end
		endcase
		out_nxt = on_nxt;
		if (otype == ZAO_OT_AUDIBLE && delay_run)
			out_nxt = on_nxt | dly_pulse;
		if (otype == ZAO_OT_SYSARM)
			out_nxt = armed;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			on_r <= 1'b0;
			left_r <= '0;
			out_r <= 1'b0;
		end else if (ce) begin
			on_r <= on_nxt;
			left_r <= left_nxt;
			out_r <= out_nxt;
		end
	end

	assign out = out_r;
endmodule : zao_output
`default_nettype wire

// ---- tb/zao_ctl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// loop classifier and operator controls facing the block
module zao_ctl_model (
	input wire logic clk,
	output logic [15:0] loop_state,
	output logic ack_n,
	output logic reset_n,
	output logic [7:0] zone_btn
);
	import zao_pkg::*;
	// idle: all loops secure, ack and reset released high, zone buttons released low
	initial begin
		loop_state = 16'h0000;
		ack_n = 1'b1;
		reset_n = 1'b1;
		zone_btn = 8'h00;
	end
	// classified state of one zone, held as a level
	task set_loop(input int z, input zao_loop_t st);
		@(posedge clk);
		loop_state[2*z +: 2] <= st;
	endtask : set_loop
	// k: 0 acknowledge, 1 reset, else zone button z
	// held six edges so the synchroniser sees a clean press
	task press(input int k, input int z);
		@(posedge clk);
		case (k)
			0: ack_n <= 1'b0;
			1: reset_n <= 1'b0;
			default: zone_btn[z] <= 1'b1;
		endcase
		repeat (6) @(posedge clk);
		ack_n <= 1'b1;
		reset_n <= 1'b1;
		zone_btn <= 8'h00;
		repeat (2) @(posedge clk);
	endtask : press
endmodule : zao_ctl_model
`default_nettype wire

// ---- tb/zao_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module zao_monitor #(
	parameter int NZ = 8,
	parameter int NO = 8,
	parameter int TICK_CYC = 20
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [2*NZ-1:0] loop_state,
	input wire logic ack_n,
	input wire logic reset_n,
	input wire logic [NZ-1:0] zone_btn,
	input wire logic arm_n,
	input wire logic delay_active,
	input wire logic [3*NO-1:0] cfg_ind_type,
	input wire logic [2:0] cfg_com1_type,
	input wire logic [2:0] cfg_com2_type,
	input wire logic [NZ-1:0] led_loop,
	input wire logic [NZ-1:0] led_alarm,
	input wire logic [NZ-1:0] zone_acked,
	input wire logic [NO-1:0] ind_out,
	input wire logic [1:0] com_out
);
	import zao_pkg::*;
	localparam int PMAX = 3 * TICK_CYC + 1;
	logic [15:0] plen_r;
	logic [15:0] plen_nxt;
	// ****************
	// helper counter
	// ****************
	// run length of pulsed output 2; a counter avoids a long repetition
	always_comb begin
		plen_nxt = 16'h0000;
		if (ind_out[2] && cfg_ind_type[8:6] == ZAO_OT_PULSED)
			plen_nxt = plen_r + 16'h0001;
	end
	always_ff @(posedge clk) begin
		plen_r <= srst ? 16'h0000 : plen_nxt;
	end
	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_loop_dark: assert property ((loop_state[1:0] == 2'h1)[*6] |-> !led_loop[0])
		else $error("loop lamp lit during alarm");
	a_loop_back: assert property (loop_state[1:0] == 2'h1 ##1 (loop_state[1:0] == 2'h0)[*6]
		|-> led_loop[0])
		else $error("loop lamp not back after secure");
	a_red_steady: assert property ((zone_acked[0] && loop_state[1:0] == 2'h0)[*6]
		|-> led_alarm[0])
		else $error("acked alarm lamp not steady");
	a_nonlatch_clear: assert property ((loop_state == 16'h0000 && cfg_com2_type == 3'h0)[*6]
		|-> !com_out[1])
		else $error("non-latch output on with loops secure");
	a_latch_hold: assert property ($fell(ind_out[0]) && cfg_ind_type[2:0] == 3'h1
		|-> $past(!reset_n || zone_btn[0], 3) || $past(!reset_n || zone_btn[0], 4))
		else $error("latched output dropped without reset");
	a_pulse_len: assert property (plen_r <= PMAX)
		else $error("pulsed output on too long");
	a_sysarm_follow: assert property (($stable(arm_n) && cfg_com1_type == 3'h5)[*6]
		|-> com_out[0] == !arm_n)
		else $error("system arm output not following arm input");
	a_audible_ack: assert property ($fell(ack_n) && cfg_com1_type == 3'h4 && !delay_active
		|-> ##[4:6] !com_out[0])
		else $error("audible output not silenced by acknowledge");
endmodule : zao_monitor
bind zao_top zao_monitor #(.NZ(NZ), .NO(NO), .TICK_CYC(TICK_CYC)) mon (.clk(clk), .srst(srst),
	.loop_state(loop_state), .ack_n(ack_n), .reset_n(reset_n), .zone_btn(zone_btn),
	.arm_n(arm_n), .delay_active(delay_active), .cfg_ind_type(cfg_ind_type),
	.cfg_com1_type(cfg_com1_type), .cfg_com2_type(cfg_com2_type), .led_loop(led_loop),
	.led_alarm(led_alarm), .zone_acked(zone_acked), .ind_out(ind_out), .com_out(com_out));
`default_nettype wire

// ---- tb/zao_top_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
	$display("FAIL %s exp %0h got %0h", n, e, a); end end
module zao_top_test;
	import zao_pkg::*;
	logic clk, srst, ce, arm_n, delay_active, cfg_load;
	logic [63:0] cfg_map, cfg_ind_secs;
	logic [23:0] cfg_ind_type;
	logic [2:0] c1t, c2t;
	logic [7:0] c1s, c2s;
	wire logic [15:0] loop_state;
	wire logic ack_n, reset_n;
	wire logic [7:0] zone_btn;
	logic [7:0] led_loop, led_alarm, zone_acked, ind_out;
	logic [1:0] com_out;
	int fail_count = 0;
	int checked = 0;
	int g, r;
	// short timebase keeps the run brief: 20 cycles stand for one second
	zao_top #(.TICK_CYC(20), .BLINK_CYC(10), .BLINK_ON(3), .DPULSE_CYC(2)) uut (.clk(clk),
		.srst(srst), .ce(ce), .loop_state(loop_state), .ack_n(ack_n), .reset_n(reset_n),
		.zone_btn(zone_btn), .arm_n(arm_n), .delay_active(delay_active), .cfg_load(cfg_load),
		.cfg_map(cfg_map), .cfg_ind_type(cfg_ind_type), .cfg_ind_secs(cfg_ind_secs),
		.cfg_com1_type(c1t), .cfg_com2_type(c2t), .cfg_com1_secs(c1s), .cfg_com2_secs(c2s),
		.led_loop(led_loop), .led_alarm(led_alarm), .zone_acked(zone_acked),
		.ind_out(ind_out), .com_out(com_out));
	zao_ctl_model pm (.clk(clk), .loop_state(loop_state), .ack_n(ack_n),
		.reset_n(reset_n), .zone_btn(zone_btn));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// lit cycles of both lamps of zone z over one blink period
	task hits(input int z);
		g = 0;
		r = 0;
		repeat (10) begin
			@(posedge clk);
			#1;
			g += int'(led_loop[z]);
			r += int'(led_alarm[z]);
		end
	endtask : hits
	task results;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	// cut a hang short
	initial begin
		#(40 * 4000);
		fail_count++;
		results();
	end
	// ****************
	// test sequence
	// ****************
	initial begin
		{srst, ce, arm_n, delay_active, cfg_load} = 5'b11100;
		cfg_map = MAP_DEFAULT;
		cfg_ind_type = 24'h24_9249;
		cfg_ind_secs = 64'h0000_0000_0000_0000;
		{c1t, c2t, c1s, c2s} = {3'h4, 3'h0, 8'h00, 8'h00};
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		wt(8);
		`CHK("loop", 8'hff, led_loop)
		`CHK("outs", 10'h000, {led_alarm, com_out})
		pm.set_loop(0, ZAO_LOOP_ALARM);
		wt(6);
		`CHK("loop0", 1'b0, led_loop[0])
		`CHK("ind", 8'h01, ind_out)
		`CHK("com", 2'h3, com_out)
		hits(0);
		`CHK("red_blink", 3, r)
		pm.press(1, 0);
		pm.set_loop(0, ZAO_LOOP_SECURE);
		wt(6);
		`CHK("loop0", 1'b1, led_loop[0])
		`CHK("com", 2'h1, com_out)
		hits(0);
		`CHK("red_unacked", 3, r)
		pm.press(0, 0);
		hits(0);
		`CHK("red_steady", 10, r)
		`CHK("aud", 1'b0, com_out[0])
		pm.set_loop(0, ZAO_LOOP_ALARM);
		wt(6);
		hits(0);
		`CHK("red_again", 3, r)
		`CHK("aud", 1'b1, com_out[0])
		pm.set_loop(0, ZAO_LOOP_SECURE);
		pm.press(2, 0);
		hits(0);
		`CHK("btn_ack", 10, r)
		pm.press(2, 0);
		wt(4);
		`CHK("red_off", 1'b0, led_alarm[0])
		`CHK("ind", 8'h00, ind_out)
		pm.set_loop(1, ZAO_LOOP_TROUBLE);
		wt(6);
		hits(1);
		`CHK("trb_blink", 3, g)
		pm.set_loop(1, ZAO_LOOP_SECURE);
		wt(6);
		hits(1);
		`CHK("trb_unacked", 3, g)
		pm.press(0, 0);
		hits(1);
		`CHK("trb_acked", 10, g)
		pm.press(1, 0);
		// bridge zones 2 and 3 to pulsed output 2, zone 3 to timed output 3
		@(posedge clk);
		cfg_map <= 64'h0000_0000_0C04_0000;
		cfg_ind_type <= 24'h24_9689;
		cfg_ind_secs <= 64'h0000_0000_0200_0000;
		{c1t, c2t, cfg_load} <= {3'h5, 3'h4, 1'b1};
		@(posedge clk);
		cfg_load <= 1'b0;
		arm_n <= 1'b0;
		wt(6);
		`CHK("arm_on", 1'b1, com_out[0])
		@(posedge clk);
		arm_n <= 1'b1;
		delay_active <= 1'b1;
		wt(6);
		`CHK("arm_off", 1'b0, com_out[0])
		g = 0;
		repeat (20) begin
			wt(1);
			g += int'(com_out[1]);
		end
		`CHK("dly_pulse", 1'b1, g > 0 && g < 20)
		@(posedge clk);
		delay_active <= 1'b0;
		pm.set_loop(2, ZAO_LOOP_ALARM);
		wt(6);
		`CHK("bridge", 2'h1, ind_out[3:2])
		// let the first pulse run out so a second start is measured on its own
		wt(70);
		`CHK("expired", 2'h0, ind_out[3:2])
		pm.set_loop(3, ZAO_LOOP_ALARM);
		wt(6);
		`CHK("bridge", 2'h3, ind_out[3:2])
		wt(70);
		`CHK("expired", 2'h0, ind_out[3:2])
		pm.set_loop(2, ZAO_LOOP_SECURE);
		pm.set_loop(3, ZAO_LOOP_SECURE);
		wt(6);
		pm.set_loop(2, ZAO_LOOP_ALARM);
		wt(6);
		`CHK("realarm", 1'b1, ind_out[2])
		pm.press(0, 0);
		pm.set_loop(2, ZAO_LOOP_SECURE);
		pm.press(1, 0);
		wt(1);
		`CHK("rst_clear", 1'b0, ind_out[2])
		results();
	end
endmodule : zao_top_test
`default_nettype wire
